// ==== core/sram_ctrl.sv ====
/*
 Controller end: AXI4-Lite register slave that issues single or burst
 commands on the SRAM pins and collects read data.
 Assumes the device shares aclk; one command is in flight at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Pins toward the device
	sram_pins_if.ctl pins
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic aw_have_r, w_have_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r, wmask, wmerge, rdata_r, rd_mux;
	logic [3:0] w_strb_r;
	logic [1:0] bresp_r, rresp_r;
	logic aw_take, w_take, ar_take, do_write, wr_ok, ar_ok;
	logic [31:0] wdata_lo_r;
	logic [3:0] wdata_hi_r;
	logic [sram_pkg::CFG_W-1:0] cfg_r;
	logic [15:0] cmd_r;
	logic pend_r, busy;
	logic [sram_pkg::BURST_W-1:0] beats_r;
	logic [sram_pkg::DATA_W-1:0] wd_r, rd_r;
	logic op0_v_r, op0_w_r, p1_v_r, p1_w_r, p2_v_r, p2_w_r;
	logic sel_n_r, sel_hi_r, write_n_r, adv_r, oe_n_r, run, ft;
	logic [sram_pkg::LANES-1:0] lanes_r;
	logic [sram_pkg::ADDR_W-1:0] addr_r;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign aw_take = awvalid & awready_r;
	assign w_take = wvalid & wready_r;
	assign ar_take = arvalid & arready_r;
	assign do_write = aw_have_r & w_have_r & ~bvalid_r;
	assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	assign wr_ok = (aw_addr_r == sram_pkg::REG_WDATA_LO) | (aw_addr_r == sram_pkg::REG_CMD)
		| (aw_addr_r == sram_pkg::REG_WDATA_HI) | (aw_addr_r == sram_pkg::REG_CONFIG);
	assign busy = pend_r | (beats_r != 2'b00) | op0_v_r | p1_v_r | p2_v_r;
	assign ar_ok = (araddr <= sram_pkg::REG_CONFIG) & (araddr[1:0] == 2'b00);
	assign rd_mux = (araddr == sram_pkg::REG_WDATA_LO) ? wdata_lo_r
		: (araddr == sram_pkg::REG_WDATA_HI) ? {28'h000_0000, wdata_hi_r}
		: (araddr == sram_pkg::REG_RDATA_LO) ? rd_r[31:0]
		: (araddr == sram_pkg::REG_RDATA_HI) ? {28'h000_0000, rd_r[35:32]}
		: (araddr == sram_pkg::REG_CMD) ? {16'h0000, cmd_r}
		: (araddr == sram_pkg::REG_STATUS) ? {30'h0000_0000, ~pins.flowthrough_sel_n, busy}
		: {27'h000_0000, cfg_r};

	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	// Address and data may arrive in either order; each is held until used
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{aw_have_r, w_have_r, bvalid_r} <= 3'b000;
			{awready_r, wready_r} <= 2'b11;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			bresp_r <= sram_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				{aw_have_r, awready_r, aw_addr_r} <= {2'b10, awaddr};
			end
			if (w_take) begin
				{w_have_r, wready_r, w_data_r, w_strb_r} <= {2'b10, wdata, wstrb};
			end
			if (do_write) begin
				{aw_have_r, w_have_r, awready_r, wready_r, bvalid_r} <= 5'b0_0111;
				bresp_r <= wr_ok ? sram_pkg::RESP_OKAY : sram_pkg::RESP_SLVERR;
			end else if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	// Unmapped or unaligned reads answer zero with SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{arready_r, rvalid_r} <= 2'b10;
			rdata_r <= 32'h0000_0000;
			rresp_r <= sram_pkg::RESP_OKAY;
		end else if (ar_take) begin
			{arready_r, rvalid_r} <= 2'b01;
			rdata_r <= ar_ok ? rd_mux : 32'h0000_0000;
			rresp_r <= ar_ok ? sram_pkg::RESP_OKAY : sram_pkg::RESP_SLVERR;
		end else if (rvalid_r && rready) begin
			{arready_r, rvalid_r} <= 2'b10;
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	// A command write that lands while one is pending replaces it
	assign wmerge = w_data_r & wmask;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdata_lo_r <= 32'h0000_0000;
			wdata_hi_r <= 4'h0;
			cfg_r <= sram_pkg::CFG_RST;
			cmd_r <= 16'h0000;
			pend_r <= 1'b0;
		end else begin
			if (run && pend_r) begin
				pend_r <= 1'b0;
			end
			if (do_write && aw_addr_r == sram_pkg::REG_WDATA_LO) begin
				wdata_lo_r <= (wdata_lo_r & ~wmask) | wmerge;
			end
			if (do_write && aw_addr_r == sram_pkg::REG_WDATA_HI && w_strb_r[0]) begin
				wdata_hi_r <= w_data_r[3:0];
			end
			if (do_write && aw_addr_r == sram_pkg::REG_CONFIG && w_strb_r[0]) begin
				cfg_r <= w_data_r[sram_pkg::CFG_W-1:0];
			end
			if (do_write && aw_addr_r == sram_pkg::REG_CMD) begin
				cmd_r <= (cmd_r & ~wmask[15:0]) | wmerge[15:0];
				pend_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Pin pipeline
	// ----------------------------------------
	// Everything here pauses with the clock enable pin, as the device does
	assign run = ~pins.clock_en_n;
	assign ft = ~pins.flowthrough_sel_n;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{op0_v_r, op0_w_r, p1_v_r, p1_w_r, p2_v_r, p2_w_r} <= 6'b00_0000;
			{sel_n_r, sel_hi_r, write_n_r, adv_r, oe_n_r} <= 5'b1_0101;
			beats_r <= 2'b00;
			lanes_r <= 4'hF;
			addr_r <= 8'h00;
			wd_r <= sram_pkg::DATA_RST;
			rd_r <= sram_pkg::DATA_RST;
		end else if (run) begin
			{p1_v_r, p1_w_r, p2_v_r, p2_w_r} <= {op0_v_r, op0_w_r, p1_v_r, p1_w_r};
			if (pend_r) begin
				// New operation loads a fresh address with all selects active
				op0_v_r <= 1'b1;
				op0_w_r <= cmd_r[sram_pkg::CMD_WRITE_BIT];
				{sel_n_r, sel_hi_r, adv_r} <= 3'b010;
				write_n_r <= ~cmd_r[sram_pkg::CMD_WRITE_BIT];
				lanes_r <= cmd_r[sram_pkg::CMD_LANE_LSB +: sram_pkg::LANES];
				addr_r <= cmd_r[sram_pkg::CMD_ADDR_LSB +: sram_pkg::ADDR_W];
				beats_r <= cmd_r[sram_pkg::CMD_BEATS_LSB +: sram_pkg::BURST_W];
				wd_r <= {wdata_hi_r, wdata_lo_r};
			end else if (beats_r != 2'b00) begin
				op0_v_r <= 1'b1;
				adv_r <= 1'b1;
				beats_r <= beats_r - 2'd1;
			end else begin
				// Idle cycles deselect, which also closes any burst
				op0_v_r <= 1'b0;
				{sel_n_r, sel_hi_r, write_n_r, adv_r} <= 4'b1010;
			end
			// Write data on the pins in the beat's late-write cycle
			oe_n_r <= ft ? ~(op0_v_r & op0_w_r) : ~(p1_v_r & p1_w_r);
			if (ft ? (p1_v_r & ~p1_w_r) : (p2_v_r & ~p2_w_r)) begin
				rd_r <= pins.dq;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign {awready, wready, bvalid, bresp} = {awready_r, wready_r, bvalid_r, bresp_r};
	assign {arready, rvalid, rdata, rresp} = {arready_r, rvalid_r, rdata_r, rresp_r};
	assign pins.select_low_first = sel_n_r;
	assign pins.select_low_second = sel_n_r;
	assign pins.select_high = sel_hi_r;
	assign pins.write_n = write_n_r;
	assign pins.load_or_advance = adv_r;
	assign pins.lane_write_n = lanes_r;
	assign pins.addr = addr_r;
	assign pins.ctl_dq_o = wd_r;
	assign pins.ctl_dq_oe_n = oe_n_r;
	// Static mode pins follow the config register one edge later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{pins.clock_en_n, pins.sleep_req, pins.out_en_n} <= 3'b000;
			{pins.flowthrough_sel_n, pins.linear_burst_sel_n} <= 2'b10;
		end else begin
			pins.flowthrough_sel_n <= ~cfg_r[sram_pkg::CFG_FT_BIT];
			pins.linear_burst_sel_n <= cfg_r[sram_pkg::CFG_ILV_BIT];
			pins.sleep_req <= cfg_r[sram_pkg::CFG_SLEEP_BIT];
			pins.out_en_n <= cfg_r[sram_pkg::CFG_OUT_OFF_BIT];
			pins.clock_en_n <= cfg_r[sram_pkg::CFG_SUSPEND_BIT];
		end
	end
endmodule
`default_nettype wire

// ==== core/sram_pkg.sv ====
/*
 Shared constants for the synchronous SRAM pin pipeline and its controller.
 Assumes both ends and the bench refer to these names with sram_pkg::.
*/
package sram_pkg;
	// ----------------------------------------
	// Memory geometry
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = 36;
	localparam int DEPTH = 256;
	localparam int BURST_W = 2;
	// ----------------------------------------
	// Controller register offsets
	// ----------------------------------------
	localparam logic [7:0] REG_WDATA_LO = 8'h00;
	localparam logic [7:0] REG_WDATA_HI = 8'h04;
	localparam logic [7:0] REG_RDATA_LO = 8'h08;
	localparam logic [7:0] REG_RDATA_HI = 8'h0C;
	localparam logic [7:0] REG_CMD = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_CONFIG = 8'h18;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_BEATS_LSB = 2;
	localparam int CMD_LANE_LSB = 4;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CFG_FT_BIT = 0;
	localparam int CFG_ILV_BIT = 1;
	localparam int CFG_SLEEP_BIT = 2;
	localparam int CFG_OUT_OFF_BIT = 3;
	localparam int CFG_SUSPEND_BIT = 4;
	localparam int CFG_W = 5;
	localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
	localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Burst direction, bit 0 set while a burst may continue
	typedef enum logic [1:0] {
		BURST_IDLE = 2'b00,
		BURST_READ = 2'b01,
		BURST_WRITE = 2'b11
	} burst_t;
endpackage

// ==== core/sram_pins_if.sv ====
/*
 Pin bundle between the SRAM device and its controller.
 Assumes both ends run on the same clock; the data wire is resolved here.
*/
`timescale 1ns/1ps
`default_nettype none
interface sram_pins_if;
	logic clock_en_n;
	logic select_low_first;
	logic select_high;
	logic select_low_second;
	logic write_n;
	logic load_or_advance;
	logic [sram_pkg::LANES-1:0] lane_write_n;
	logic [sram_pkg::ADDR_W-1:0] addr;
	logic out_en_n;
	logic sleep_req;
	logic flowthrough_sel_n;
	logic linear_burst_sel_n;
	logic [sram_pkg::DATA_W-1:0] dev_dq_o;
	logic dev_dq_oe_n;
	logic [sram_pkg::DATA_W-1:0] ctl_dq_o;
	logic ctl_dq_oe_n;
	logic [sram_pkg::DATA_W-1:0] dq;

	// Shared data wire: the device wins while it drives, else controller value
	assign dq = !dev_dq_oe_n ? dev_dq_o : ctl_dq_o;

	modport dev (
		input clock_en_n, select_low_first, select_high, select_low_second,
		input write_n, load_or_advance, lane_write_n, addr, out_en_n,
		input sleep_req, flowthrough_sel_n, linear_burst_sel_n, dq,
		output dev_dq_o, dev_dq_oe_n
	);
	modport ctl (
		output clock_en_n, select_low_first, select_high, select_low_second,
		output write_n, load_or_advance, lane_write_n, addr, out_en_n,
		output sleep_req, flowthrough_sel_n, linear_burst_sel_n,
		output ctl_dq_o, ctl_dq_oe_n,
		input dq
	);
endinterface
`default_nettype wire

// ==== core/burst_addr_gen.sv ====
/*
 Two-bit burst address counter for the SRAM device.
 Assumes load and step are already qualified by the clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_addr_gen (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic load,
	input wire logic step,
	input wire logic [sram_pkg::BURST_W-1:0] start,
	input wire logic interleave,
	// Low address bits for the next continuation beat
	output logic [sram_pkg::BURST_W-1:0] next_lo
);
	logic [sram_pkg::BURST_W-1:0] base_r;
	logic [sram_pkg::BURST_W-1:0] cnt_r;
	logic [sram_pkg::BURST_W-1:0] cnt_inc;

	// Linear adds the beat count, interleaved flips bits; wraps inside 4
	assign cnt_inc = cnt_r + 2'd1;
	assign next_lo = interleave ? (base_r ^ cnt_inc) : (base_r + cnt_inc);

	// A fresh load restarts the count from the presented address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_r <= 2'b00;
			cnt_r <= 2'b00;
		end else if (load) begin
			base_r <= start;
			cnt_r <= 2'b00;
		end else if (step) begin
			cnt_r <= cnt_inc;
		end
	end
endmodule
`default_nettype wire

// ==== core/sram_device.sv ====
/*
 Synchronous SRAM device end: command pipeline, late write, read
 output register, burst counter and byte-lane memory.
 Assumes the controller shares aclk and keeps to the pin protocol.
*/
// What this block does
// - Clock enable high freezes all pipeline state
// - Synchronous inputs sampled on rising clock edges
// - Controller holds load low for new ops
// - Selected only with all three selects active
// - Read starts and latches address when selected
// - Pipelined read drives after the following edge
// - Write accepted when selected with write low
// - Each lane strobe writes its nine-bit lane
// - Write with no lane strobes changes nothing
// - Pipelined write data taken at third edge
// - Flow-through read drives right after address
// - Flow-through write data taken at second edge
// - Back-to-back reads and writes, no idles
// - Load high continues burst at next address
// - Mode pin low flow-through, high pipelined
// - Burst order pin low linear, high interleaved
// - Reads happen only while sleep is low
`timescale 1ns/1ps
`default_nettype none
module sram_device (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pins toward the controller
	sram_pins_if.dev pins,
	// Local status
	output logic burst_active
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic run;
	logic selected;
	logic load;
	logic cont;
	logic ft_mode;
	logic interleave;
	logic cmd_valid;
	logic cmd_write;
	logic [sram_pkg::ADDR_W-1:0] cmd_addr;
	logic [sram_pkg::BURST_W-1:0] next_lo;
	sram_pkg::burst_t burst_r;
	sram_pkg::burst_t burst_nxt;

	logic a_valid_r;
	logic a_write_r;
	logic [sram_pkg::ADDR_W-1:0] a_addr_r;
	logic [sram_pkg::LANES-1:0] a_lanes_r;
	logic b_valid_r;
	logic b_write_r;
	logic [sram_pkg::ADDR_W-1:0] b_addr_r;
	logic [sram_pkg::LANES-1:0] b_lanes_r;

	logic wr_go;
	logic [sram_pkg::ADDR_W-1:0] wr_addr;
	logic [sram_pkg::LANES-1:0] wr_lanes_n;
	logic rd_go;
	logic [sram_pkg::ADDR_W-1:0] rd_addr;
	logic [sram_pkg::DATA_W-1:0] rd_word;
	logic drive_nxt;

	logic drive_r;
	logic [sram_pkg::DATA_W-1:0] dout_r;
	logic dq_oe_n_r;

	// ----------------------------------------
	// Pin decode
	// ----------------------------------------
	// Every qualifier below is sampled at the rising edge only
	assign run = ~pins.clock_en_n;
	assign selected = ~pins.select_low_first & pins.select_high
		& ~pins.select_low_second;
	assign load = run & ~pins.load_or_advance;
	// Continuation needs a live burst; selects and write pin not looked at
	assign cont = run & pins.load_or_advance & burst_r[0];
	assign ft_mode = ~pins.flowthrough_sel_n;
	assign interleave = pins.linear_burst_sel_n;

	// ----------------------------------------
	// Burst address counter
	// ----------------------------------------
	burst_addr_gen u_burst (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(load & selected),
		.step(cont),
		.start(pins.addr[sram_pkg::BURST_W-1:0]),
		.interleave(interleave),
		.next_lo(next_lo)
	);

	// ----------------------------------------
	// Command stage inputs
	// ----------------------------------------
	// Direction comes from the pin on a load, from the burst otherwise
	assign cmd_write = load ? ~pins.write_n
		: (burst_r == sram_pkg::BURST_WRITE);
	// Reads are dropped while sleep is requested; writes still land
	assign cmd_valid = ((load & selected) | cont)
		& (cmd_write | ~pins.sleep_req);
	assign cmd_addr = load ? pins.addr
		: {a_addr_r[sram_pkg::ADDR_W-1:sram_pkg::BURST_W], next_lo};

	// Deselect or a non-selected load closes the burst
	always_comb begin
		burst_nxt = burst_r;
		if (load) begin
			if (!selected) begin
				burst_nxt = sram_pkg::BURST_IDLE;
			end else if (!pins.write_n) begin
				burst_nxt = sram_pkg::BURST_WRITE;
			end else begin
				burst_nxt = sram_pkg::BURST_READ;
			end
		end
	end

	// ----------------------------------------
	// Command pipeline
	// ----------------------------------------
	// Two chained stages let reads and writes follow back to back
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_r <= sram_pkg::BURST_IDLE;
			a_valid_r <= 1'b0;
			a_write_r <= 1'b0;
			a_addr_r <= '0;
			a_lanes_r <= '1;
			b_valid_r <= 1'b0;
			b_write_r <= 1'b0;
			b_addr_r <= '0;
			b_lanes_r <= '1;
		end else if (run) begin
			burst_r <= burst_nxt;
			a_valid_r <= cmd_valid;
			a_write_r <= cmd_write;
			a_addr_r <= cmd_addr;
			a_lanes_r <= pins.lane_write_n;
			b_valid_r <= a_valid_r;
			b_write_r <= a_write_r;
			b_addr_r <= a_addr_r;
			b_lanes_r <= a_lanes_r;
		end
	end

	// ----------------------------------------
	// Late write selection
	// ----------------------------------------
	// Single late write in flow-through, double late write when pipelined
	assign wr_go = ft_mode ? (a_valid_r & a_write_r)
		: (b_valid_r & b_write_r);
	assign wr_addr = ft_mode ? a_addr_r : b_addr_r;
	assign wr_lanes_n = ft_mode ? a_lanes_r : b_lanes_r;

	// ----------------------------------------
	// Read source selection
	// ----------------------------------------
	// Flow-through reads the array with the address being registered now
	assign rd_go = ft_mode ? (cmd_valid & ~cmd_write)
		: (a_valid_r & ~a_write_r);
	assign rd_addr = ft_mode ? cmd_addr : a_addr_r;

	// ----------------------------------------
	// Byte-lane memory
	// ----------------------------------------
	// One array per lane so a lane strobe gates only its own bits
	for (genvar i = 0; i < sram_pkg::LANES; i++) begin : g_lane
		logic [sram_pkg::LANE_W-1:0] mem [sram_pkg::DEPTH];

		assign rd_word[i*sram_pkg::LANE_W +: sram_pkg::LANE_W] = mem[rd_addr];

		// Data pins sampled at the late-write edge
		always_ff @(posedge aclk) begin
			if (run && wr_go && !wr_lanes_n[i]) begin
				mem[wr_addr] <= pins.dq[i*sram_pkg::LANE_W +: sram_pkg::LANE_W];
			end
		end
	end

	// ----------------------------------------
	// Output register and drivers
	// ----------------------------------------
	// Drive state freezes with the pipe; output enable acts every cycle
	assign drive_nxt = run ? rd_go : drive_r;

	// Read data is loaded only on a read so the last value stays parked
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive_r <= 1'b0;
			dout_r <= sram_pkg::DATA_RST;
			dq_oe_n_r <= 1'b1;
		end else begin
			drive_r <= drive_nxt;
			if (run && rd_go) begin
				dout_r <= rd_word;
			end
			dq_oe_n_r <= ~(drive_nxt & ~pins.out_en_n);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Output enable is registered, so a release lags the pin by one edge
	assign pins.dev_dq_o = dout_r;
	assign pins.dev_dq_oe_n = dq_oe_n_r;
	// Bit 0 of the burst state is set for both live directions
	assign burst_active = burst_r[0];
endmodule
`default_nettype wire

// ==== tb/sram_pins_checker.sv ====
/*
 Pin checker for the SRAM device and controller pair.
 Assumes one clock and the bench wiring it beside the pin bundle.
*/
`timescale 1ns/1ps
`default_nettype none
module sram_pins_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pin bundle
	input wire logic clock_en_n,
	input wire logic select_low_first,
	input wire logic select_high,
	input wire logic select_low_second,
	input wire logic write_n,
	input wire logic load_or_advance,
	input wire logic [sram_pkg::LANES-1:0] lane_write_n,
	input wire logic out_en_n,
	input wire logic sleep_req,
	input wire logic flowthrough_sel_n,
	input wire logic [sram_pkg::DATA_W-1:0] dev_dq_o,
	input wire logic dev_dq_oe_n,
	input wire logic ctl_dq_oe_n
);
	// ----
	// Decoded pin cycles
	// ----
	wire logic sel = !select_low_first && select_high && !select_low_second;
	wire logic go = !clock_en_n && sel && !load_or_advance;
	wire logic rd = go && write_n && !sleep_req && !out_en_n;
	wire logic wr = go && !write_n && lane_write_n != '1;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A read, then the cycle its data must be on the pins
	sequence s_rd_pipe; rd && flowthrough_sel_n ##1 !clock_en_n && !out_en_n ##1 1'h1; endsequence
	sequence s_rd_flow; rd && !flowthrough_sel_n ##1 1'h1; endsequence
	property p_pipe_read; s_rd_pipe |-> !dev_dq_oe_n; endproperty
	property p_flow_read; s_rd_flow |-> !dev_dq_oe_n; endproperty
	property p_pipe_wdata; wr && flowthrough_sel_n ##1 !clock_en_n
		|=> !ctl_dq_oe_n && dev_dq_oe_n; endproperty
	property p_flow_wdata; wr && !flowthrough_sel_n |=> !ctl_dq_oe_n && dev_dq_oe_n; endproperty
	// Frozen pipeline must not move the data wire
	property p_freeze; clock_en_n
		|=> $stable(dev_dq_oe_n) && $stable(dev_dq_o) && $stable(ctl_dq_oe_n); endproperty
	property p_deselect; (!clock_en_n && !sel && !load_or_advance) [*3] |-> dev_dq_oe_n; endproperty
	property p_sleep; (sleep_req && !clock_en_n) [*4] |-> dev_dq_oe_n; endproperty
	property p_out_off; (out_en_n && !clock_en_n) [*2] |-> dev_dq_oe_n; endproperty
	property p_one_driver; !dev_dq_oe_n |-> ctl_dq_oe_n; endproperty
	a_pipe_read:
	assert property (p_pipe_read) else $error("pipelined read not driven");
	a_flow_read:
	assert property (p_flow_read) else $error("flow-through read not driven");
	a_pipe_wdata:
	assert property (p_pipe_wdata) else $error("pipelined write data slot wrong");
	a_flow_wdata:
	assert property (p_flow_wdata) else $error("flow-through write data slot wrong");
	a_freeze:
	assert property (p_freeze) else $error("pins moved while frozen");
	a_deselect:
	assert property (p_deselect) else $error("drives while deselected");
	a_sleep:
	assert property (p_sleep) else $error("drives while asleep");
	a_out_off:
	assert property (p_out_off) else $error("drives with output disabled");
	a_one_driver:
	assert property (p_one_driver) else $error("both ends drive data");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 Bench: controller and device joined by the pin bundle, driven over AXI4-Lite.
 Assumes the package, bundle and both ends are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ----
	// Signals
	// ----
	logic aclk = 1'h0, aresetn = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, rd_v;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, burst_active;
	logic [1:0] bresp, rresp;
	logic [33:0] exp_r[$];
	logic [1:0] exp_b[$];
	logic [35:0] mem[4];
	int n_mismatch = 0, num_checks = 0, cycles = 0;
	sram_pins_if pins();
	sram_device sram_device_inst (.aclk, .aresetn, .pins(pins.dev), .burst_active);
	sram_ctrl sram_ctrl_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .pins(pins.ctl));
	sram_pins_checker chk_inst (.aclk, .aresetn, .clock_en_n(pins.clock_en_n),
		.select_low_first(pins.select_low_first), .select_high(pins.select_high),
		.select_low_second(pins.select_low_second), .write_n(pins.write_n),
		.load_or_advance(pins.load_or_advance), .lane_write_n(pins.lane_write_n),
		.out_en_n(pins.out_en_n), .sleep_req(pins.sleep_req),
		.flowthrough_sel_n(pins.flowthrough_sel_n), .dev_dq_o(pins.dev_dq_o),
		.dev_dq_oe_n(pins.dev_dq_oe_n), .ctl_dq_oe_n(pins.ctl_dq_oe_n));
	initial forever #25 aclk = ~aclk;
	// ----
	// Compare, report, bus tasks
	// ----
	task automatic chk_r(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic [1:0] got, input logic [1:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t write response %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Each task waits an edge first so no strobe is set twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		@(posedge aclk);
		exp_b.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		fork
			begin
				do @(posedge aclk); while (awready !== 1'h1);
				awvalid <= 1'h0;
			end
			begin
				do @(posedge aclk); while (wready !== 1'h1);
				wvalid <= 1'h0;
			end
		join
		do @(posedge aclk); while (bvalid !== 1'h1);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic c = 1'h0, input logic [33:0] e = 34'h0);
		@(posedge aclk);
		if (c) exp_r.push_back(e);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		rd_v = rdata;
		rready <= 1'h0;
	endtask
	// Polling is bounded by the run timeout
	task automatic cmd(input logic [7:0] a, input logic [3:0] ln, input logic [1:0] bt,
		input logic w);
		wr(sram_pkg::REG_CMD, {16'h0000, a, ln, bt, 1'h0, w});
		do rd(sram_pkg::REG_STATUS); while (rd_v[0] !== 1'h0);
	endtask
	task automatic put(input logic [35:0] d);
		wr(sram_pkg::REG_WDATA_LO, d[31:0]);
		wr(sram_pkg::REG_WDATA_HI, {28'h000_0000, d[35:32]});
	endtask
	task automatic back(input logic [35:0] e);
		rd(sram_pkg::REG_RDATA_LO, 1'h1, {2'h0, e[31:0]});
		rd(sram_pkg::REG_RDATA_HI, 1'h1, {2'h0, 28'h000_0000, e[35:32]});
	endtask
	// Result watcher takes the oldest note as each answer appears
	always @(posedge aclk) begin
		if (rvalid === 1'h1 && rready === 1'h1 && exp_r.size() > 0) chk_r({rresp, rdata}, exp_r.pop_front());
		if (bvalid === 1'h1 && bready === 1'h1) chk_b(bresp, exp_b.pop_front());
	end
	// Hang guard, far above the several hundred cycles the tests need
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			results();
		end
	end
	// ----
	// Main sequence
	// ----
	initial begin
		logic [35:0] d, m;
		logic [7:0] a;
		logic [3:0] ln;
		void'($urandom(18368));
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rd(sram_pkg::REG_CONFIG, 1'h1, 34'h0);
		rd(8'h1C, 1'h1, {sram_pkg::RESP_SLVERR, 32'h0000_0000});
		wr(sram_pkg::REG_STATUS, 32'h0000_0000, sram_pkg::RESP_SLVERR);
		// Only the low byte lane may land when a single strobe is set
		wstrb <= 4'h1;
		wr(sram_pkg::REG_WDATA_LO, 32'hFFFF_FFFF);
		wstrb <= 4'hF;
		rd(sram_pkg::REG_WDATA_LO, 1'h1, 34'h0_0000_00FF);
		$display("register test done");
		for (int ft = 0; ft < 2; ft++) begin
			wr(sram_pkg::REG_CONFIG, 32'(ft));
			rd(sram_pkg::REG_STATUS, 1'h1, 34'(ft << 1));
			a = 8'($urandom) & 8'hFC;
			d = 36'({$urandom, $urandom});
			put(d);
			cmd(a, 4'h0, 2'h3, 1'h1);
			cmd(a | 8'h03, 4'hF, 2'h0, 1'h0);
			back(d);
			for (int k = 0; k < 2; k++) begin
				ln = k ? 4'hF : 4'($urandom);
				m = 36'({$urandom, $urandom});
				put(m);
				cmd(a, ln, 2'h0, 1'h1);
				for (int i = 0; i < sram_pkg::LANES; i++) if (!ln[i]) d[i*9 +: 9] = m[i*9 +: 9];
				cmd(a, 4'hF, 2'h0, 1'h0);
				back(d);
			end
			for (int i = 0; i < 4; i++) begin
				mem[i] = 36'({$urandom, $urandom});
				put(mem[i]);
				cmd(a | 8'(i), 4'h0, 2'h0, 1'h1);
			end
			for (int il = 0; il < 2; il++) begin
				wr(sram_pkg::REG_CONFIG, 32'(ft | il << 1));
				cmd(a | 8'h01, 4'hF, 2'h3, 1'h0);
				back(mem[il ? 2 : 0]);
			end
			$display("mode %0d test done", ft);
		end
		wr(sram_pkg::REG_CONFIG, 32'h0000_0010);
		wr(sram_pkg::REG_CMD, {16'h0000, a, 8'hF0});
		repeat (5) @(posedge aclk);
		rd(sram_pkg::REG_STATUS, 1'h1, 34'h1);
		wr(sram_pkg::REG_CONFIG, 32'h0000_0000);
		do rd(sram_pkg::REG_STATUS); while (rd_v[0] !== 1'h0);
		back(mem[0]);
		cmd(a | 8'h01, 4'hF, 2'h0, 1'h0);
		back(mem[1]);
		for (int k = 2; k < 4; k++) begin
			wr(sram_pkg::REG_CONFIG, 32'(1 << k));
			cmd(a | 8'h02, 4'hF, 2'h0, 1'h0);
			// A dropped or undriven read leaves the controller's own word on the wire
			back(mem[3]);
		end
		wr(sram_pkg::REG_CONFIG, 32'h0000_0000);
		cmd(a | 8'h02, 4'hF, 2'h0, 1'h0);
		back(mem[2]);
		$display("suspend and quiet test done");
		results();
	end
endmodule
`default_nettype wire
